// ==== core/usi_core.sv ====
// universal serial shift unit with apb register access
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usi_core
	import usi_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        serial_clock_pin,
	output var  logic        serial_clock_out,
	output var  logic        serial_clock_oe,
	input  wire logic        serial_data_in_pin,
	output var  logic        data_out_pin,
	output var  logic        data_out_oe,
	output var  logic        sda_out,
	output var  logic        sda_oe,
	input  wire logic        data_dir_out,
	input  wire logic        clock_dir_out,
	input  wire logic        timer_match,
	input  wire logic        global_irq_enable,
	output var  logic        start_irq_req,
	output var  logic        ovf_irq_req
);
	state_type s;
	state_type next_s;

	// register selection shared by read and write paths
	function automatic logic [1:0] reg_select(input logic [11:0] addr);
		if (addr == OFFSET_DATA) begin
			return 2'h1;
		end else if (addr == OFFSET_STATUS) begin
			return 2'h2;
		end else if (addr == OFFSET_CONTROL) begin
			return 2'h3;
		end else begin
			return 2'h0;
		end
	endfunction : reg_select

	logic       access;
	logic       wr_data;
	logic       wr_status;
	logic       wr_control;
	logic       two_wire;
	logic       three_wire;
	logic       ext_level;
	logic       ext_rise;
	logic       ext_fall;
	logic       scl_rise;
	logic       scl_fall;
	logic       soft_strobe;
	logic       cnt_tick;
	logic       shift_tick;
	logic       start_cond;
	logic       stop_cond;
	logic       any_edge_start;
	logic       latch_open;
	logic       ovf_event;
	logic [7:0] status_view;
	logic [7:0] control_view;

	// bus decode; a write lands on the edge that sees pready high
	always_comb begin
		access      = psel & penable & s.pready;
		wr_data     = access & pwrite & (reg_select(paddr) == 2'h1);
		wr_status   = access & pwrite & (reg_select(paddr) == 2'h2);
		wr_control  = access & pwrite & (reg_select(paddr) == 2'h3);
		two_wire    = s.wire_mode[1];
		three_wire  = (s.wire_mode == WM_THREE);
		status_view = {s.start_flag, s.ovf_flag, s.stop_flag,
			two_wire & (s.shift[7] != s.sda_s2), s.cnt};
		control_view = {s.start_ie, s.ovf_ie, s.wire_mode, s.clk_src, 2'h0};
	end

	// clock edge detection and clock source selection
	always_comb begin
		ext_level   = s.sw_clk_mode ? s.port_clk : s.scl_s2;
		ext_rise    = ext_level & ~s.ext_prev;
		ext_fall    = ~ext_level & s.ext_prev;
		scl_rise    = s.scl_s2 & ~s.scl_prev;
		scl_fall    = ~s.scl_s2 & s.scl_prev;
		soft_strobe = wr_control & pwdata[CTRL_SWCLK] & (s.clk_src == CS_SOFT);
		if (s.clk_src[1]) begin
			cnt_tick   = ext_rise | ext_fall;
			shift_tick = s.clk_src[0] ? ext_fall : ext_rise;
		end else if (s.clk_src == CS_TIMER) begin
			cnt_tick   = timer_match;
			shift_tick = timer_match;
		end else begin
			cnt_tick   = soft_strobe;
			shift_tick = soft_strobe;
		end
		ovf_event = cnt_tick & (s.cnt == CNT_MAX) & ~wr_status;
	end

	// start and stop seen on delayed data while the clock is high
	always_comb begin
		start_cond = two_wire & s.scl_s2 & s.sda_dly[START_DELAY_CYCLES-1]
			& ~s.sda_dly[START_DELAY_CYCLES-2];
		stop_cond  = two_wire & s.scl_s2 & ~s.sda_dly[START_DELAY_CYCLES-1]
			& s.sda_dly[START_DELAY_CYCLES-2];
		any_edge_start = ~two_wire & s.clk_src[1] & ~s.sw_clk_mode
			& (scl_rise | scl_fall);
		latch_open = ~s.clk_src[1] | (s.clk_src[0] ? ext_level : ~ext_level);
	end

	// next state of the whole unit
	always_comb begin
		next_s = s;
		next_s.scl_s1   = serial_clock_pin;
		next_s.scl_s2   = s.scl_s1;
		next_s.sda_s1   = serial_data_in_pin;
		next_s.sda_s2   = s.sda_s1;
		next_s.sda_dly  = {s.sda_dly[START_DELAY_CYCLES-2:0], s.sda_s2};
		next_s.ext_prev = ext_level;
		next_s.scl_prev = s.scl_s2;
		// shift register: a bus write beats a shift in the same cycle
		if (wr_data) begin
			next_s.shift = pwdata[7:0];
		end else if (shift_tick) begin
			next_s.shift = {s.shift[6:0], s.sda_s2};
		end
		// counter: written value beats a count edge
		if (wr_status) begin
			next_s.cnt = pwdata[3:0];
		end else if (cnt_tick) begin
			next_s.cnt = s.cnt + CNT_ONE;
		end
		// sticky flags, a start or stop set in the clearing cycle wins
		if (wr_status & pwdata[STAT_START]) begin
			next_s.start_flag = 1'b0;
		end
		if (start_cond | any_edge_start) begin
			next_s.start_flag = 1'b1;
		end
		if (wr_status & pwdata[STAT_OVF]) begin
			next_s.ovf_flag = 1'b0;
		end
		if (ovf_event) begin
			next_s.ovf_flag = 1'b1;
		end
		if (wr_status & pwdata[STAT_STOP]) begin
			next_s.stop_flag = 1'b0;
		end
		if (stop_cond) begin
			next_s.stop_flag = 1'b1;
		end
		// control register and its strobes
		if (wr_control) begin
			next_s.start_ie    = pwdata[CTRL_SIE];
			next_s.ovf_ie      = pwdata[CTRL_OIE];
			next_s.wire_mode   = pwdata[CTRL_WM_HI:CTRL_WM_LO];
			next_s.clk_src     = pwdata[CTRL_CS_HI:CTRL_CS_LO];
			next_s.sw_clk_mode = pwdata[CTRL_SWCLK] & pwdata[CTRL_CS_HI];
			if (pwdata[CTRL_TOGGLE]) begin
				next_s.port_clk = ~s.port_clk;
			end
		end
		// clock holds: after start on next falling edge, after overflow in wire mode 11
		next_s.start_hold = next_s.start_flag & two_wire & (s.start_hold | scl_fall);
		next_s.ovf_hold   = next_s.ovf_flag & (s.wire_mode == WM_TWO_HOLD)
			& (s.ovf_hold | ovf_event);
		// output latch follows bit 7 while open
		if (latch_open) begin
			next_s.latch = next_s.shift[7];
		end
		// pin drivers per wire mode; mode 00 leaves the pins alone
		next_s.do_out  = next_s.latch;
		// data drivers follow the mode being entered, so a mode change never leaves one on
		next_s.do_oe   = (next_s.wire_mode == WM_THREE) & data_dir_out;
		next_s.sda_oe  = next_s.wire_mode[1] & data_dir_out & ~next_s.latch;
		if (two_wire) begin
			next_s.scl_out = 1'b0;
			next_s.scl_oe  = next_s.start_hold | next_s.ovf_hold
				| (clock_dir_out & ~next_s.port_clk);
		end else begin
			next_s.scl_out = next_s.port_clk;
			next_s.scl_oe  = three_wire & clock_dir_out;
		end
		// interrupt requests
		next_s.start_irq = next_s.start_flag & next_s.start_ie & global_irq_enable;
		next_s.ovf_irq   = next_s.ovf_flag & next_s.ovf_ie & global_irq_enable;
		// apb: one wait state, read data captured with pready
		next_s.pready  = psel & penable & ~s.pready;
		next_s.pslverr = 1'b0;
		next_s.prdata  = '0;
		if (psel & penable & ~s.pready) begin
			if (reg_select(paddr) == 2'h1) begin
				next_s.prdata = {24'h000000, s.shift};
			end else if (reg_select(paddr) == 2'h2) begin
				next_s.prdata = {24'h000000, status_view};
			end else if (reg_select(paddr) == 2'h3) begin
				next_s.prdata = {24'h000000, control_view};
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register, except sda_out, which is tied low
	assign prdata           = s.prdata;
	assign pready           = s.pready;
	assign pslverr          = s.pslverr;
	assign serial_clock_out = s.scl_out;
	assign serial_clock_oe  = s.scl_oe;
	assign data_out_pin     = s.do_out;
	assign data_out_oe      = s.do_oe;
	assign sda_out          = 1'b0;
	assign sda_oe           = s.sda_oe;
	assign start_irq_req    = s.start_irq;
	assign ovf_irq_req      = s.ovf_irq;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// sequences of bus actions
	sequence data_write_seq;
		wr_data;
	endsequence
	sequence ovf_clear_seq;
		wr_status & pwdata[STAT_OVF] & ~ovf_event;
	endsequence
	sequence start_clear_seq;
		wr_status & pwdata[STAT_START] & ~start_cond & ~any_edge_start;
	endsequence

	data_write_a: assert property (data_write_seq |=> s.shift == $past(pwdata[7:0]))
		else $error("data write lost or shifted");
	ovf_wrap_a: assert property (ovf_event |=> s.ovf_flag && s.cnt == 4'h0)
		else $error("counter wrap missed overflow");
	ovf_clear_a: assert property (ovf_clear_seq |=> !s.ovf_flag && !s.ovf_hold)
		else $error("overflow flag or hold not cleared");
	start_clear_a: assert property (start_clear_seq |=> !s.start_flag ##1 !s.scl_oe || s.ovf_hold
		|| (clock_dir_out && !s.port_clk))
		else $error("start clear did not release clock");
	start_hold_a: assert property (two_wire && s.start_flag && scl_fall && !wr_status |=> s.start_hold
		&& s.scl_oe)
		else $error("start hold not applied");
	sda_delay_a: assert property (s.sda_dly[START_DELAY_CYCLES-1] == $past(s.sda_s2, 5))
		else $error("data delay length wrong");
	two_wire_only_a: assert property (!two_wire |-> !start_cond && !s.sda_oe)
		else $error("start detector active outside two-wire");
	both_edges_a: assert property (s.clk_src[1] && (ext_rise || ext_fall) && !wr_status
		|=> s.cnt == $past(s.cnt) + 4'h1)
		else $error("external edge not counted");
	shift_left_a: assert property (shift_tick && !wr_data
		|=> s.shift == {$past(s.shift[6:0]), $past(s.sda_s2)})
		else $error("shift wrong");
	ovf_hold_a: assert property (ovf_event && s.wire_mode == WM_TWO_HOLD && !wr_status
		|=> s.ovf_hold && s.scl_oe)
		else $error("overflow did not hold clock");
	edge_start_a: assert property (any_edge_start |=> s.start_flag)
		else $error("clock edge did not set start flag");
	start_irq_a: assert property (s.start_flag && s.start_ie && global_irq_enable
		&& !wr_status && !wr_control |=> start_irq_req)
		else $error("start interrupt not requested");
endmodule : usi_core
`default_nettype wire

// ==== core/usi_pkg.sv ====
// constants, register map and state record of the serial shift unit
// Summary of operation
// - two-wire follows bus protocol, no filtering
// - master clocks; only slave stretches the clock
// - two-wire shifts output on falling clock edge
// - start sets flag, then holds clock low
// - writing one clears start flag, releases hold
// - two-wire slave samples data on rising clock
// - counter overflow holds clock low until released; the code holds only in wire mode 11
// - acknowledge by driving data low, preset 14
// - read bit one means slave drives data
// - bytes flow one way until stop or start
// - start detector delays data 50 to 300 ns
// - start detector only in two-wire mode
// - external clock counts both edges
// - counter preset to F overflows next edge
// - data register unbuffered, write beats shift
// - shift left on the selected clock source
// - inputs feed shifter even with wire mode zero
// - bit 7 drives output through clock-phase latch
// - external clock edge sets start flag otherwise
// - start flag with enables requests interrupt
// - counter wrap 15 to 0 sets overflow
// - writing one clears overflow, releases hold
// - mode 00 disables outputs, 01 three-wire
package usi_pkg;
	// register byte offsets on the bus
	localparam logic [11:0] OFFSET_DATA    = 12'h000;
	localparam logic [11:0] OFFSET_STATUS  = 12'h004;
	localparam logic [11:0] OFFSET_CONTROL = 12'h008;
	// status field positions
	localparam int STAT_START = 7;
	localparam int STAT_OVF   = 6;
	localparam int STAT_STOP  = 5;
	localparam int STAT_COLL  = 4;
	// control field positions
	localparam int CTRL_SIE     = 7;
	localparam int CTRL_OIE     = 6;
	localparam int CTRL_WM_HI   = 5;
	localparam int CTRL_WM_LO   = 4;
	localparam int CTRL_CS_HI   = 3;
	localparam int CTRL_CS_LO   = 2;
	localparam int CTRL_SWCLK   = 1;
	localparam int CTRL_TOGGLE  = 0;
	// wire mode and clock source encodings
	localparam logic [1:0] WM_OFF      = 2'h0;
	localparam logic [1:0] WM_THREE    = 2'h1;
	localparam logic [1:0] WM_TWO_HOLD = 2'h3;
	localparam logic [1:0] CS_SOFT     = 2'h0;
	localparam logic [1:0] CS_TIMER    = 2'h1;
	// start detector data delay and counter constants
	localparam int CLK_PERIOD_NS      = 10;
	localparam int START_DELAY_MIN_NS = 50;
	localparam int START_DELAY_MAX_NS = 300;
	localparam int START_DELAY_CYCLES = (START_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_DELAY_LIMIT  = START_DELAY_MAX_NS / CLK_PERIOD_NS;
	localparam logic [3:0] CNT_MAX = 4'hF;
	localparam logic [3:0] CNT_ONE = 4'h1;
	// whole state of the unit
	typedef struct packed {
		logic                          scl_s1;
		logic                          scl_s2;
		logic                          sda_s1;
		logic                          sda_s2;
		logic [START_DELAY_CYCLES-1:0] sda_dly;
		logic                          ext_prev;
		logic                          scl_prev;
		logic [7:0]                    shift;
		logic [3:0]                    cnt;
		logic                          start_flag;
		logic                          ovf_flag;
		logic                          stop_flag;
		logic                          start_ie;
		logic                          ovf_ie;
		logic [1:0]                    wire_mode;
		logic [1:0]                    clk_src;
		logic                          sw_clk_mode;
		logic                          port_clk;
		logic                          start_hold;
		logic                          ovf_hold;
		logic                          latch;
		logic                          do_out;
		logic                          do_oe;
		logic                          sda_oe;
		logic                          scl_out;
		logic                          scl_oe;
		logic                          start_irq;
		logic                          ovf_irq;
		logic                          pready;
		logic                          pslverr;
		logic [31:0]                   prdata;
	} state_type;
endpackage : usi_pkg

// ==== dv/usi_bus_master.sv ====
// two-wire bus master model on open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module usi_bus_master (
	input  wire logic scl_in,
	input  wire logic sda_in,
	output var  logic scl_low,
	output var  logic sda_low,
	output var  logic stuck
);
	localparam realtime HALF = 62.5;
	// lines released at start, pull-ups give high
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stuck = 1'b0;
	end
	// data falls while clock high, then master pulls clock low
	task automatic start_cond;
		// step off the system clock edge so no pin moves as it is sampled
		#1;
		sda_low = 1'b1;
		#(4 * HALF);
		scl_low = 1'b1;
		#HALF;
	endtask : start_cond
	// msb first, data changes only while clock low, one direction per byte
	task automatic send_byte(input logic [7:0] b);
		int n;
		#1;
		for (int i = 7; i >= 0; i--) begin
			sda_low = ~b[i];
			#HALF;
			scl_low = 1'b0;
			n = 0;
			// slave may stretch the clock
			while (scl_in !== 1'b1 && n < 3000) begin
				#10;
				n++;
			end
			if (n >= 3000) stuck = 1'b1;
			#HALF;
			scl_low = 1'b1;
		end
	endtask : send_byte
	// acknowledge slot: data released, one clock pulse, data sampled while clock high
	task automatic clock_ack(output logic a);
		int n;
		#1;
		sda_low = 1'b0;
		#HALF;
		scl_low = 1'b0;
		n = 0;
		while (scl_in !== 1'b1 && n < 3000) begin
			#10;
			n++;
		end
		if (n >= 3000) stuck = 1'b1;
		#HALF;
		a = sda_in;
		scl_low = 1'b1;
		#HALF;
	endtask : clock_ack
	// release, pull low, release: three edges
	task automatic pulse_clock;
		#1;
		scl_low = 1'b0;
		#HALF;
		scl_low = 1'b1;
		#HALF;
		scl_low = 1'b0;
		#HALF;
	endtask : pulse_clock
endmodule : usi_bus_master
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench of the serial shift unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb import usi_pkg::*;;
	typedef struct packed {
		logic       err;
		logic [7:0] exp;
		logic [7:0] mask;
		logic       rd;
	} note_type;
	logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        serial_clock_out, serial_clock_oe, data_out_pin, data_out_oe, sda_out, sda_oe;
	logic        data_dir_out, clock_dir_out, timer_match, global_irq_enable, start_irq_req, ovf_irq_req;
	logic        scl_low, sda_low, stuck, ack;
	logic [7:0]  d, b;
	int          seed, error_cnt, comparisons;
	note_type    notes[$];
	note_type    note;
	wire logic   scl_wire = ~scl_low & ~(serial_clock_oe & ~serial_clock_out);
	wire logic   sda_wire = ~sda_low & ~(sda_oe & ~sda_out);
	usi_core u_usi_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clock_pin(scl_wire), .serial_clock_out(serial_clock_out),
		.serial_clock_oe(serial_clock_oe), .serial_data_in_pin(sda_wire), .data_out_pin(data_out_pin),
		.data_out_oe(data_out_oe), .sda_out(sda_out), .sda_oe(sda_oe), .data_dir_out(data_dir_out),
		.clock_dir_out(clock_dir_out), .timer_match(timer_match), .global_irq_enable(global_irq_enable),
		.start_irq_req(start_irq_req), .ovf_irq_req(ovf_irq_req));
	usi_bus_master u_usi_bus_master (.scl_in(scl_wire), .sda_in(sda_wire), .scl_low(scl_low),
		.sda_low(sda_low), .stuck(stuck));
	// system clock
	always #5 ref_clk = ~ref_clk;
	// compare each finished transfer with the oldest note, at the edge that samples pready high
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			`CHK("pslverr", note.err, pslverr)
			if (note.rd) `CHK("prdata", note.exp & note.mask, prdata[7:0] & note.mask)
		end
	end
	// print counts and verdict
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// one transfer: setup, access held until pready at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v, input logic [7:0] m, input logic e);
		int   n;
		logic rdy;
		notes.push_back({e, v, m, ~wr});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, v};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		rdy = 1'b0;
		while (!rdy && n < 20) begin
			@(posedge ref_clk);
			rdy = (pready === 1'b1);
			n++;
		end
		if (!rdy) begin
			error_cnt++;
			end_sim();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : apb
	// main sequence
	initial begin
		{ref_clk, psel, penable, pwrite, paddr, pwdata} = '0;
		{data_dir_out, clock_dir_out, timer_match, global_irq_enable} = '0;
		sys_rst = 1'b1;
		seed = 11;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		apb(0, OFFSET_DATA, 8'h00, 8'hFF, 0);
		apb(0, OFFSET_STATUS, 8'h00, 8'hCF, 0);
		apb(0, OFFSET_CONTROL, 8'h00, 8'hFF, 0);
		apb(0, 12'h00C, 8'h00, 8'hFF, 1);
		$display("test reset done");
		d = 8'($random(seed));
		data_dir_out <= 1'b1;
		apb(1, OFFSET_CONTROL, 8'h10, 8'hFF, 0);
		apb(1, OFFSET_DATA, d, 8'hFF, 0);
		apb(1, OFFSET_STATUS, 8'hCD, 8'hFF, 0);
		apb(0, OFFSET_CONTROL, 8'h10, 8'hFF, 0);
		@(negedge ref_clk);
		`CHK("data_out_pin", d[7], data_out_pin)
		`CHK("data_out_oe", 1'b1, data_out_oe)
		@(posedge ref_clk);
		repeat (3) apb(1, OFFSET_CONTROL, 8'h12, 8'hFF, 0);
		apb(0, OFFSET_STATUS, 8'h40, 8'hCF, 0);
		apb(0, OFFSET_DATA, {d[4:0], 3'h7}, 8'hFF, 0);
		$display("test soft strobe done");
		global_irq_enable <= 1'b1;
		apb(1, OFFSET_CONTROL, 8'h44, 8'hFF, 0);
		apb(1, OFFSET_STATUS, 8'h4F, 8'hFF, 0);
		timer_match <= 1'b1;
		@(posedge ref_clk);
		timer_match <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("ovf_irq_req", 1'b1, ovf_irq_req)
		@(posedge ref_clk);
		apb(0, OFFSET_STATUS, 8'h40, 8'hCF, 0);
		apb(1, OFFSET_STATUS, 8'h45, 8'hFF, 0);
		apb(0, OFFSET_STATUS, 8'h05, 8'hCF, 0);
		@(negedge ref_clk);
		`CHK("ovf_irq_req cleared", 1'b0, ovf_irq_req)
		@(posedge ref_clk);
		$display("test timer done");
		data_dir_out <= 1'b0;
		global_irq_enable <= 1'b1;
		b = 8'($random(seed));
		apb(1, OFFSET_STATUS, 8'hC0, 8'hFF, 0);
		apb(1, OFFSET_CONTROL, 8'hB8, 8'hFF, 0);
		u_usi_bus_master.start_cond();
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("start hold", 1'b1, serial_clock_oe)
		`CHK("start_irq_req", 1'b1, start_irq_req)
		@(posedge ref_clk);
		apb(0, OFFSET_STATUS, 8'h80, 8'hC0, 0);
		apb(1, OFFSET_STATUS, 8'h80, 8'hFF, 0);
		u_usi_bus_master.send_byte(b);
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("overflow hold", 1'b1, serial_clock_oe)
		@(posedge ref_clk);
		apb(0, OFFSET_STATUS, 8'h40, 8'hCF, 0);
		apb(0, OFFSET_DATA, b, 8'hFF, 0);
		data_dir_out <= 1'b1;
		apb(1, OFFSET_DATA, 8'h00, 8'hFF, 0);
		apb(1, OFFSET_STATUS, 8'h4E, 8'hFF, 0);
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("hold released", 1'b0, serial_clock_oe)
		`CHK("ack driven", 1'b1, sda_oe)
		@(posedge ref_clk);
		u_usi_bus_master.clock_ack(ack);
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("ack seen", 1'b0, ack)
		`CHK("ack hold", 1'b1, serial_clock_oe)
		`CHK("master stalled", 1'b0, stuck)
		@(posedge ref_clk);
		data_dir_out <= 1'b0;
		$display("test two-wire done");
		apb(1, OFFSET_CONTROL, 8'h08, 8'hFF, 0);
		apb(1, OFFSET_STATUS, 8'hC0, 8'hFF, 0);
		u_usi_bus_master.pulse_clock();
		repeat (6) @(posedge ref_clk);
		apb(0, OFFSET_STATUS, 8'h83, 8'hCF, 0);
		$display("test clock edges done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
